/* File: logic/async_serial_receiver.sv */
// Notes on behaviour
// - sampling of the receive line starts only while receive_enable is one.
// - falling line starts divide-by-16 count; low at count eight confirms start.
// - finished frame goes to receive_buffer and pulses rx_complete_irq.
// - faulty frame still stored; complete and error interrupts fire together.
// - clearing receive_enable mid-frame aborts; buffer, status and interrupts untouched.
// - frame completing while buffer still unread flags overrun.
// - received parity differing from configured parity flags a parity error.
// - missing stop bit flags a framing error.
// - each error flag is set in the same cycle as rx_error_irq.
// - error status clears on buffer read or next frame; new frame sets own flags.
// - each completion starts the block service at once, before the next frame.
// - receive block service raises one vectored request when its count ends.
// - transmit service ends on last word with one request; next tx completion another.
// - rx_error_request_flag is set on every reception error for polling.
// - completion vector depends on vector_table_select; control word address fixed.
// - error vector depends on vector_table_select; control word address fixed.
// - oversampling tick runs at serial clock from prescaler and 10-bit compare.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`include "async_rx_cfg.svh"

module async_serial_receiver (
  // clock, reset, enable
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial line
  input  wire logic        rxd_i,
  // transmitter event
  input  wire logic        tx_complete_irq_i,
  // receive interrupts
  output logic             rx_complete_irq_o,
  output logic             rx_error_irq_o,
  // block transfer service
  output logic             xfer_valid_o,
  output logic      [7:0]  xfer_data_o,
  output logic             tx_load_o,
  output logic             vec_req_o,
  output logic      [15:0] vec_addr_o
);

  // ******************************************************************
  // register bus decode
  // ******************************************************************
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  async_rx_pkg::async_mode_control_t ctrl_reg;
  async_rx_pkg::rx_error_status_t    rx_error_status_reg;
  async_rx_pkg::rx_error_status_t    err_next;
  async_rx_pkg::rx_state_t           state_reg;
  logic [11:0]        baud_reg;
  logic [7:0]         receive_buffer_reg;
  logic               buf_full_reg;
  logic               rx_error_request_flag_reg;
  logic               rx_done_flag_reg;
  logic [`SVC_W-1:0]  rx_svc_reg;
  logic [`SVC_W-1:0]  tx_svc_reg;
  logic               svc_pend_reg;
  logic [3:0]         ovs_reg;
  logic [3:0]         bit_idx_reg;
  logic [7:0]         shift_reg;
  logic               par_bit_reg;
  logic               prev_hi_reg;

  wire        access   = psel && penable && pready;
  wire        wr       = access && pwrite;
  wire        rd       = access && !pwrite;
  wire        rd_buf   = rd && hit(paddr, `OFS_RXBUF);
  wire        mapped   = hit(paddr, `OFS_CTRL) || hit(paddr, `OFS_BAUD) ||
                         hit(paddr, `OFS_RXBUF) || hit(paddr, `OFS_ERRSTAT) ||
                         hit(paddr, `OFS_FLAGS) || hit(paddr, `OFS_RXSVC) ||
                         hit(paddr, `OFS_TXSVC) || hit(paddr, `OFS_VEC);
  wire [15:0] vec_done = ctrl_reg.vector_table_select ? `VEC_RX_DONE_1
                                                      : `VEC_RX_DONE_0;
  wire [15:0] vec_err  = ctrl_reg.vector_table_select ? `VEC_RX_ERR_1
                                                      : `VEC_RX_ERR_0;
  wire [15:0] vec_tx   = ctrl_reg.vector_table_select ? `VEC_TX_DONE_1
                                                      : `VEC_TX_DONE_0;
  wire [31:0] rd_mux   =
      hit(paddr, `OFS_CTRL)    ? {27'h0, ctrl_reg} :
      hit(paddr, `OFS_BAUD)    ? {20'h0, baud_reg} :
      hit(paddr, `OFS_RXBUF)   ? {24'h0, receive_buffer_reg} :
      hit(paddr, `OFS_ERRSTAT) ? {29'h0, rx_error_status_reg} :
      hit(paddr, `OFS_FLAGS)   ? {29'h0, buf_full_reg, rx_done_flag_reg,
                                  rx_error_request_flag_reg} :
      hit(paddr, `OFS_RXSVC)   ? {24'h0, rx_svc_reg} :
      hit(paddr, `OFS_TXSVC)   ? {24'h0, tx_svc_reg} :
      hit(paddr, `OFS_VEC)     ? {vec_err, vec_done} : 32'h0000_0000;

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce_i) begin
      pready  <= psel && penable && !pready;
      prdata  <= (psel && penable && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  // ******************************************************************
  // configuration registers
  // ******************************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `CTRL_RST;
      baud_reg <= `BAUD_RST;
    end else if (ce_i && wr) begin
      if (hit(paddr, `OFS_CTRL))
        ctrl_reg <= pwdata[`CTRL_W-1:0];
      if (hit(paddr, `OFS_BAUD))
        baud_reg <= pwdata[11:0];
    end
  end

  // ******************************************************************
  // oversampling tick
  // ******************************************************************
  logic tick;

  baud_tick_gen u_tick (
    .core_clk_i     (core_clk_i),
    .rst_i          (rst_i),
    .ce_i           (ce_i),
    .run_i          (ctrl_reg.receive_enable),
    .prescale_sel_i (baud_reg[11:`BAUD_SEL_LSB]),
    .compare_i      (baud_reg[`BAUD_CMP_W-1:0]),
    .tick_o         (tick)
  );

  // ******************************************************************
  // receive sequencer
  // ******************************************************************
  wire       par_on     = (ctrl_reg.parity_mode != `PAR_NONE);
  wire [3:0] last_bit   = ctrl_reg.char8 ? 4'h7 : 4'h6;
  wire       bit_mid    = tick && (ovs_reg == `OVS_BIT_LAST);
  wire       start_mid  = tick && (ovs_reg == `OVS_START_LAST);
  wire       fall       = tick && prev_hi_reg && !rxd_i;
  wire       frame_done = ctrl_reg.receive_enable && (state_reg == async_rx_pkg::RX_STOP)
                          && bit_mid;
  wire [7:0] rx_data    = ctrl_reg.char8 ? shift_reg : {1'b0, shift_reg[7:1]};
  wire       par_calc   = (^rx_data) ^ par_bit_reg;
  wire       par_bad    = (ctrl_reg.parity_mode == `PAR_ZERO) ? par_bit_reg :
                          (ctrl_reg.parity_mode == `PAR_ODD)  ? !par_calc :
                          (ctrl_reg.parity_mode == `PAR_EVEN) ? par_calc : 1'b0;

  always_comb begin
    err_next.parity_err  = par_bad;
    err_next.framing_err = !rxd_i;
    err_next.overrun_err = buf_full_reg;
  end

  wire any_err = frame_done && (err_next != 3'h0);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg   <= async_rx_pkg::RX_HUNT;
      ovs_reg     <= 4'h0;
      bit_idx_reg <= 4'h0;
      shift_reg   <= 8'h00;
      par_bit_reg <= 1'b0;
      prev_hi_reg <= 1'b0;
    end else if (ce_i) begin
      if (!ctrl_reg.receive_enable) begin
        state_reg   <= async_rx_pkg::RX_HUNT;
        prev_hi_reg <= 1'b0;
      end else begin
        if (tick)
          ovs_reg <= ovs_reg + 4'h1;
        unique case (state_reg)
          async_rx_pkg::RX_HUNT: begin
            if (tick)
              prev_hi_reg <= rxd_i;
            if (fall) begin
              state_reg <= async_rx_pkg::RX_START;
              ovs_reg   <= 4'h0;
            end
          end
          async_rx_pkg::RX_START: begin
            if (start_mid) begin
              ovs_reg     <= 4'h0;
              bit_idx_reg <= 4'h0;
              state_reg   <= rxd_i ? async_rx_pkg::RX_HUNT : async_rx_pkg::RX_DATA;
              prev_hi_reg <= rxd_i;
            end
          end
          async_rx_pkg::RX_DATA: begin
            if (bit_mid) begin
              shift_reg   <= {rxd_i, shift_reg[7:1]};
              bit_idx_reg <= bit_idx_reg + 4'h1;
              if (bit_idx_reg == last_bit)
                state_reg <= par_on ? async_rx_pkg::RX_PARITY : async_rx_pkg::RX_STOP;
            end
          end
          async_rx_pkg::RX_PARITY: begin
            if (bit_mid) begin
              par_bit_reg <= rxd_i;
              state_reg   <= async_rx_pkg::RX_STOP;
            end
          end
          async_rx_pkg::RX_STOP: begin
            if (bit_mid) begin
              if (!par_on)
                par_bit_reg <= 1'b0;
              prev_hi_reg <= rxd_i;
              state_reg   <= async_rx_pkg::RX_HUNT;
            end
          end
        endcase
      end
    end
  end

  // ******************************************************************
  // receive buffer, error status, flags
  // ******************************************************************
  // a completing frame wins over a same-cycle buffer read or flag clear
  wire svc_read = svc_pend_reg; // block service reads the buffer itself

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      receive_buffer_reg  <= 8'h00;
      buf_full_reg        <= 1'b0;
      rx_error_status_reg <= 3'h0;
    end else if (ce_i) begin
      if (frame_done) begin
        receive_buffer_reg  <= rx_data;
        buf_full_reg        <= 1'b1;
        rx_error_status_reg <= err_next;
      end else if (rd_buf || svc_read) begin
        buf_full_reg        <= 1'b0;
        rx_error_status_reg <= 3'h0;
      end
    end
  end

  wire flag_clr_err  = wr && hit(paddr, `OFS_FLAGS) && pwdata[`FLAG_ERR_BIT];
  wire flag_clr_done = wr && hit(paddr, `OFS_FLAGS) && pwdata[`FLAG_DONE_BIT];

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rx_error_request_flag_reg <= 1'b0;
      rx_done_flag_reg          <= 1'b0;
      rx_complete_irq_o         <= 1'b0;
      rx_error_irq_o            <= 1'b0;
    end else if (ce_i) begin
      rx_error_request_flag_reg <= any_err || (rx_error_request_flag_reg && !flag_clr_err);
      rx_done_flag_reg          <= frame_done || (rx_done_flag_reg && !flag_clr_done);
      rx_complete_irq_o         <= frame_done;
      rx_error_irq_o            <= any_err;
    end
  end

  // ******************************************************************
  // block transfer service
  // ******************************************************************
  wire rx_svc_on  = (rx_svc_reg != 8'h00);
  wire tx_svc_on  = (tx_svc_reg != 8'h00);
  wire rx_svc_end = svc_pend_reg && (rx_svc_reg == 8'h01);
  wire rx_plain   = frame_done && !rx_svc_on;
  wire tx_evt     = tx_complete_irq_i;
  wire tx_vec     = tx_evt && (!tx_svc_on || (tx_svc_reg == 8'h01));

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      svc_pend_reg <= 1'b0;
      rx_svc_reg   <= 8'h00;
      tx_svc_reg   <= 8'h00;
    end else if (ce_i) begin
      svc_pend_reg <= frame_done && rx_svc_on;
      if (svc_pend_reg)
        rx_svc_reg <= rx_svc_reg - 8'h01;
      else if (wr && hit(paddr, `OFS_RXSVC))
        rx_svc_reg <= pwdata[`SVC_W-1:0];
      if (tx_evt && tx_svc_on)
        tx_svc_reg <= tx_svc_reg - 8'h01;
      else if (wr && hit(paddr, `OFS_TXSVC))
        tx_svc_reg <= pwdata[`SVC_W-1:0];
    end
  end

  // receive requests take precedence over a transmit request in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      xfer_valid_o <= 1'b0;
      xfer_data_o  <= 8'h00;
      tx_load_o    <= 1'b0;
      vec_req_o    <= 1'b0;
      vec_addr_o   <= 16'h0000;
    end else if (ce_i) begin
      xfer_valid_o <= svc_pend_reg;
      xfer_data_o  <= svc_pend_reg ? receive_buffer_reg : 8'h00;
      tx_load_o    <= tx_evt && tx_svc_on;
      vec_req_o    <= rx_svc_end || rx_plain || tx_vec;
      vec_addr_o   <= (rx_svc_end || rx_plain) ? vec_done :
                      tx_vec ? vec_tx : 16'h0000;
    end
  end

endmodule

/* File: logic/async_rx_cfg.svh */
`ifndef ASYNC_RX_CFG_SVH
`define ASYNC_RX_CFG_SVH

// ********************************************************************
// register offsets (byte addresses)
// ********************************************************************
`define OFS_CTRL       12'h000
`define OFS_BAUD       12'h004
`define OFS_RXBUF      12'h008
`define OFS_ERRSTAT    12'h00c
`define OFS_FLAGS      12'h010
`define OFS_RXSVC      12'h014
`define OFS_TXSVC      12'h018
`define OFS_VEC        12'h01c

// ********************************************************************
// field positions and reset values
// ********************************************************************
`define CTRL_W         5
`define CTRL_RST       5'h00
`define BAUD_CMP_W     10
`define BAUD_SEL_LSB   10
`define BAUD_RST       12'h000
`define FLAG_ERR_BIT   0
`define FLAG_DONE_BIT  1
`define FLAG_FULL_BIT  2
`define SVC_W          8

// ********************************************************************
// parity modes
// ********************************************************************
`define PAR_NONE       2'h0
`define PAR_ZERO       2'h1
`define PAR_ODD        2'h2
`define PAR_EVEN       2'h3

// ********************************************************************
// vector and control word addresses
// ********************************************************************
`define VEC_RX_DONE_0  16'h002c
`define VEC_RX_DONE_1  16'h802c
`define CW_RX_DONE     16'hfe2c
`define VEC_RX_ERR_0   16'h002a
`define VEC_RX_ERR_1   16'h802a
`define CW_RX_ERR      16'hfe2a
`define VEC_TX_DONE_0  16'h002e
`define VEC_TX_DONE_1  16'h802e

// ********************************************************************
// oversampling counts
// ********************************************************************
`define OVS_BIT_LAST   4'hf
`define OVS_START_LAST 4'h7

`endif

/* File: logic/async_rx_pkg.sv */
package async_rx_pkg;

  typedef enum logic [2:0] {
    RX_HUNT,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP
  } rx_state_t;

  typedef struct packed {
    logic       vector_table_select;
    logic       char8;
    logic [1:0] parity_mode;
    logic       receive_enable;
  } async_mode_control_t;

  typedef struct packed {
    logic parity_err;
    logic framing_err;
    logic overrun_err;
  } rx_error_status_t;

endpackage

/* File: logic/baud_tick_gen.sv */
`timescale 1ns/1ns
`include "async_rx_cfg.svh"

module baud_tick_gen (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // configuration
  input  wire logic       run_i,
  input  wire logic [1:0] prescale_sel_i,
  input  wire logic [9:0] compare_i,
  // oversampling tick
  output logic            tick_o
);

  logic [4:0] pre_cnt_reg;
  logic [9:0] tm_cnt_reg;
  logic       half_reg;
  logic [4:0] pre_last;
  logic       pre_tick;
  logic       match;

  // count clock is the system clock divided by 1, 4, 16 or 32
  assign pre_last = (prescale_sel_i == 2'h0) ? 5'h00 :
                    (prescale_sel_i == 2'h1) ? 5'h03 :
                    (prescale_sel_i == 2'h2) ? 5'h0f : 5'h1f;
  assign pre_tick = (pre_cnt_reg == pre_last);
  assign match    = pre_tick && (tm_cnt_reg == compare_i);

  // the serial clock is half the match rate; each of its periods is one
  // oversampling tick, so a bit lasts sixteen of them
  always_ff @(posedge core_clk_i) begin
    if (rst_i || (ce_i && !run_i)) begin
      pre_cnt_reg <= 5'h00;
      tm_cnt_reg  <= 10'h000;
      half_reg    <= 1'b0;
      tick_o      <= 1'b0;
    end else if (ce_i) begin
      pre_cnt_reg <= pre_tick ? 5'h00 : pre_cnt_reg + 5'h01;
      if (match) begin
        tm_cnt_reg <= 10'h000;
        half_reg   <= !half_reg;
      end else if (pre_tick) begin
        tm_cnt_reg <= tm_cnt_reg + 10'h001;
      end
      tick_o <= match && half_reg;
    end
  end

endmodule

/* File: dv/async_rx_checker_assertions.sv */
`timescale 1ns/1ns
`include "async_rx_cfg.svh"

module async_rx_checker (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        pready,
  // line and events
  input  wire logic        rxd_i,
  input  wire logic        tx_complete_irq_i,
  input  wire logic        rx_complete_irq_o,
  input  wire logic        rx_error_irq_o,
  input  wire logic        xfer_valid_o,
  input  wire logic        tx_load_o,
  input  wire logic        vec_req_o,
  input  wire logic [15:0] vec_addr_o
);
  // shadow of the control word, so vector and enable checks need no peeking inside
  logic [4:0] ctrl_reg;
  logic       en_prev_reg;
  wire        ctrl_wr = psel & penable & pready & pwrite & (paddr == `OFS_CTRL);
  wire        vts     = ctrl_reg[4];

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_reg    <= 5'h00;
      en_prev_reg <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= pwdata[4:0];
      end
      en_prev_reg <= ctrl_reg[0];
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // ************************************************************
  // assertions
  // ************************************************************
  AST_ERR_WITH_DONE: assert property (rx_error_irq_o |-> rx_complete_irq_o)
    else $error("error pulse without completion pulse");
  AST_DONE_PULSE: assert property (rx_complete_irq_o |=> !rx_complete_irq_o)
    else $error("completion pulse longer than one cycle");
  AST_OFF_QUIET: assert property (!ctrl_reg[0] && !en_prev_reg |-> !rx_complete_irq_o && !rx_error_irq_o)
    else $error("receive event while disabled");
  AST_FRAMING: assert property (rx_complete_irq_o && !$past(rxd_i) && !$past(rxd_i, 4) |-> rx_error_irq_o)
    else $error("low stop bit without error pulse");
  AST_RX_VEC: assert property (vec_req_o && rx_complete_irq_o && !$past(tx_complete_irq_i) |-> vec_addr_o == (vts ? 16'h802c : 16'h002c))
    else $error("wrong completion vector");
  AST_TX_SVC: assert property (tx_complete_irq_i |=> tx_load_o || vec_req_o)
    else $error("transmit event not served");
  AST_TX_VEC: assert property ($past(tx_complete_irq_i) && vec_req_o && !rx_complete_irq_o && !xfer_valid_o |-> vec_addr_o == (vts ? 16'h802e : 16'h002e))
    else $error("wrong transmit vector");
  AST_XFER_AFTER_DONE: assert property (xfer_valid_o |-> $past(rx_complete_irq_o))
    else $error("block move not right after completion");
endmodule

bind async_serial_receiver async_rx_checker chk_u (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .rxd_i(rxd_i),
  .tx_complete_irq_i(tx_complete_irq_i), .rx_complete_irq_o(rx_complete_irq_o),
  .rx_error_irq_o(rx_error_irq_o), .xfer_valid_o(xfer_valid_o), .tx_load_o(tx_load_o),
  .vec_req_o(vec_req_o), .vec_addr_o(vec_addr_o)
);

/* File: dv/serial_line_model.sv */
`timescale 1ns/1ns
`include "async_rx_cfg.svh"

module serial_line_model #(
  parameter int BIT_CLKS = 32
) (
  // clock
  input  wire logic core_clk_i,
  // serial line, idles high like a pulled-up wire
  output logic      rxd_o
);
  initial rxd_o = 1'b1;

  task automatic hold_bit(input logic b);
    rxd_o <= b;
    repeat (BIT_CLKS) @(posedge core_clk_i);
  endtask

  // flip_par and bad_stop break the frame on purpose
  task automatic send(input logic [7:0] d, input logic c8, input logic [1:0] par,
                      input logic flip_par, input logic bad_stop);
    logic p;
    p = ^d[6:0] ^ (c8 & d[7]);
    // idle high first: a freshly enabled receiver must see one high sample before an edge
    repeat (8) @(posedge core_clk_i);
    hold_bit(1'b0);
    for (int i = 0; i < 7 + int'(c8); i++) begin
      hold_bit(d[i]);
    end
    case (par)
      `PAR_ZERO: hold_bit(flip_par);
      `PAR_ODD:  hold_bit(~p ^ flip_par);
      `PAR_EVEN: hold_bit(p ^ flip_par);
      default:   ;
    endcase
    hold_bit(~bad_stop);
    rxd_o <= 1'b1;
  endtask
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ns
`include "async_rx_cfg.svh"

module testbench;
  logic        core_clk_i = 1'b0;
  logic        rst_i, ce_i, psel, penable, pwrite, tx_complete_irq_i;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, serr, rx_complete_irq_o, rx_error_irq_o;
  logic        xfer_valid_o, tx_load_o, vec_req_o, rxd, c8;
  logic [7:0]  xfer_data_o, d, last_xfer;
  logic [15:0] vec_addr_o, last_vec;
  logic [1:0]  par;
  integer      seed = 32'ha17de351;
  int          err_total, comparisons, n_done, n_err, n_xfer, n_load, n_vec;

  always #20 core_clk_i = ~core_clk_i;

  async_serial_receiver dut_u (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd_i(rxd), .tx_complete_irq_i(tx_complete_irq_i),
    .rx_complete_irq_o(rx_complete_irq_o), .rx_error_irq_o(rx_error_irq_o),
    .xfer_valid_o(xfer_valid_o), .xfer_data_o(xfer_data_o), .tx_load_o(tx_load_o),
    .vec_req_o(vec_req_o), .vec_addr_o(vec_addr_o));
  serial_line_model #(.BIT_CLKS(32)) line_u (.core_clk_i(core_clk_i), .rxd_o(rxd));

  // ************************************************************
  // event monitor and helpers
  // ************************************************************
  always @(posedge core_clk_i) begin
    if (rx_complete_irq_o === 1'b1) n_done++;
    if (rx_error_irq_o === 1'b1) n_err++;
    if (tx_load_o === 1'b1) n_load++;
    if (xfer_valid_o === 1'b1) begin
      n_xfer++;
      last_xfer = xfer_data_o;
    end
    if (vec_req_o === 1'b1) begin
      n_vec++;
      last_vec = vec_addr_o;
    end
  end

  function automatic logic [31:0] ctrl(logic en, logic [1:0] p, logic b8, logic vts);
    return {27'h0, vts, b8, p, en};
  endfunction

  function automatic logic [31:0] exp_char(logic [7:0] v, logic b8);
    return b8 ? {24'h0, v} : {25'h0, v[6:0]};
  endfunction

  task automatic wrap_up;
    if (err_total == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge core_clk_i);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge core_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd   = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      wrap_up();
    end
  endtask

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  task automatic mark;
    #1;
    n_done = 0;
    n_err  = 0;
    n_xfer = 0;
    n_load = 0;
    n_vec  = 0;
  endtask

  initial begin
    #4000000;
    err_total++;
    wrap_up();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    tx_complete_irq_i = 1'b0;
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rchk("ctrl reset", `OFS_CTRL, 32'h0);
    rchk("rx count reset", `OFS_RXSVC, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped err", {31'h0, serr}, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, `OFS_BAUD, 32'hc05);
    rchk("baud", `OFS_BAUD, 32'h0c05);
    // fastest generator setting keeps frames short: 32 clocks a bit
    apb(1'b1, `OFS_BAUD, 32'h0);
    mark();
    line_u.send(8'h5a, 1'b1, `PAR_NONE, 1'b0, 1'b0);
    check("done while off", n_done, 0);
    rchk("flags while off", `OFS_FLAGS, 32'h0);
    for (int m = 0; m < 8; m++) begin
      par = m[1:0];
      c8 = m[2];
      d = 8'($random(seed));
      apb(1'b1, `OFS_CTRL, ctrl(1'b1, par, c8, 1'b0));
      mark();
      line_u.send(d, c8, par, 1'b0, 1'b0);
      check("done", n_done, 1);
      check("err", n_err, 0);
      check("vector", {16'h0, last_vec}, 32'h002c);
      rchk("status", `OFS_ERRSTAT, 32'h0);
      rchk("data", `OFS_RXBUF, exp_char(d, c8));
    end
    rchk("vectors", `OFS_VEC, 32'h002a002c);
    apb(1'b1, `OFS_CTRL, ctrl(1'b1, `PAR_ODD, 1'b1, 1'b0));
    for (int k = 0; k < 2; k++) begin
      d = 8'($random(seed));
      apb(1'b1, `OFS_FLAGS, 32'h3);
      mark();
      line_u.send(d, 1'b1, `PAR_ODD, k == 0, k == 1);
      check("err pulse", n_err, 1);
      rchk("flags", `OFS_FLAGS, 32'h7);
      rchk("status", `OFS_ERRSTAT, (k == 0) ? 32'h4 : 32'h2);
      rchk("err data", `OFS_RXBUF, {24'h0, d});
      rchk("status read", `OFS_ERRSTAT, 32'h0);
    end
    // faulty frame left unread, then a clean one: only overrun remains
    line_u.send(8'($random(seed)), 1'b1, `PAR_ODD, 1'b1, 1'b0);
    d = 8'($random(seed));
    mark();
    line_u.send(d, 1'b1, `PAR_ODD, 1'b0, 1'b0);
    check("overrun pulse", n_err, 1);
    rchk("overrun", `OFS_ERRSTAT, 32'h1);
    rchk("overrun data", `OFS_RXBUF, {24'h0, d});
    mark();
    fork
      line_u.send(8'hc3, 1'b1, `PAR_ODD, 1'b0, 1'b0);
      begin
        repeat (160) @(posedge core_clk_i);
        apb(1'b1, `OFS_CTRL, ctrl(1'b0, `PAR_ODD, 1'b1, 1'b0));
      end
    join
    check("abort done", n_done + n_err, 0);
    rchk("abort status", `OFS_ERRSTAT, 32'h0);
    rchk("abort data", `OFS_RXBUF, {24'h0, d});
    apb(1'b1, `OFS_CTRL, ctrl(1'b1, `PAR_NONE, 1'b1, 1'b1));
    rchk("vectors hi", `OFS_VEC, 32'h802a802c);
    apb(1'b1, `OFS_RXSVC, 32'h2);
    mark();
    for (int k = 0; k < 2; k++) begin
      d = 8'($random(seed));
      line_u.send(d, 1'b1, `PAR_NONE, 1'b0, 1'b0);
      check("moved data", {24'h0, last_xfer}, {24'h0, d});
    end
    check("moves", n_xfer, 2);
    check("rx requests", n_vec, 1);
    check("rx vector", {16'h0, last_vec}, 32'h802c);
    rchk("rx count end", `OFS_RXSVC, 32'h0);
    apb(1'b1, `OFS_TXSVC, 32'h2);
    mark();
    repeat (3) begin
      @(posedge core_clk_i);
      tx_complete_irq_i <= 1'b1;
      @(posedge core_clk_i);
      tx_complete_irq_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
    end
    check("tx loads", n_load, 2);
    check("tx requests", n_vec, 2);
    check("tx vector", {16'h0, last_vec}, 32'h802e);
    rchk("tx count end", `OFS_TXSVC, 32'h0);
    wrap_up();
  end
endmodule
